// File: hw/tbp_pkg.sv
// Purpose: shared constants and types of the buffered two-wire slave port
// Assumes: 7-bit slave addressing, byte-wide payload
// Notes:   an event word is a 2-bit kind above one data byte
package tbp_pkg;
  localparam logic [6:0] SLV_ADDR    = 7'h11;
  localparam logic [6:0] GEN_CALL    = 7'h00;
  localparam logic [7:0] SUB_CPU_FIX = 8'h78;
  localparam logic [7:0] SUB_CPU_INC = 8'h79;
  localparam logic [7:0] SUB_DRAM    = 8'h7a;
  localparam logic [7:0] SUB_CMD     = 8'h7b;
  localparam logic [7:0] SUB_DATA    = 8'h7c;
  localparam logic [7:0] SUB_STAT    = 8'h7d;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam int         BUF_BYTES   = 48;
  localparam logic [5:0] BUF_LAST    = 6'h2f;
  localparam logic [5:0] BUF_FULL    = 6'h30;
  localparam logic [8:0] MAX_LEN     = 9'h100;
  localparam int         FIFO_DEPTH  = 32;
  localparam int         EV_W        = 10;
  localparam int         ST_BUSY     = 7;
  localparam int         ST_INVALID  = 6;
  localparam int         ST_NODATA   = 5;
  localparam logic [7:0] STOP_PAD    = 8'h00;

  typedef enum logic [1:0] {
    EV_SUB  = 2'h0,
    EV_DATA = 2'h1,
    EV_STOP = 2'h2,
    EV_RD   = 2'h3
  } tbp_ev_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_ADDR = 3'h1,
    L_AACK = 3'h2,
    L_WR   = 3'h3,
    L_WACK = 3'h4,
    L_RD   = 3'h5,
    L_RACK = 3'h6,
    L_IGN  = 3'h7
  } tbp_lstate_t;

  typedef enum logic [1:0] {
    C_SUB     = 2'h0,
    C_DIRECT  = 2'h1,
    C_COLLECT = 2'h2,
    C_COPY    = 2'h3
  } tbp_cstate_t;
endpackage

// File: hw/tbp_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level that holds for several destination cycles
// Notes:   first stage feeds the second stage only
`timescale 1ns/100ps
module tbp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// File: hw/tbp_fifo.sv
// Purpose: synchronous fifo with valid and ready on both sides
// Assumes: depth is a power of two
// Notes:   extra pointer bit tells full from empty
`timescale 1ns/100ps
module tbp_fifo #(
  parameter int W = 10,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign in_ready  = (wp[AW] == rp[AW]) | (wp[AW-1:0] != rp[AW-1:0]);
  assign out_valid = wp != rp;
  assign out_data  = mem[rp[AW-1:0]];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wp[AW-1:0]] <= in_data;
  end
endmodule

// File: hw/tbp_port.sv
// Purpose: buffered two-wire slave port facing an external host master
// Assumes: link_clk oversamples scl and sda; clk runs the buffer side
// Notes:   write bytes cross by toggle handshake into a 32-word fifo
// Function
// R1: the port is only ever a slave, taking bytes on writes, giving on reads.
// R2: the port may hold scl low and the master waits for scl to rise.
// R3: the general call address is never acknowledged, sda stays released.
// R4: the first byte after the address of a write is the subaddress.
// R5: the master sends at most 256 bytes after address and subaddress.
// R6: successive data bytes go on to successive targets with no new address; every byte here keeps the telegram's subaddress in wr_sub.
// R7: bus bytes are caught in real time into a 48-byte buffer.
// R8: scl is held low while the buffer is processed before the stop.
// R9: a new telegram is held after its address until the old one is done.
// R10: address 0x22/0x23 and subaddresses 0x78 to 0x7d select the targets.
// R11: the status byte shows busy, invalid and no-data in bits 7, 6, 5.
// R12: dram bytes collect and are copied out at 48 bytes or at stop.
// R13: command telegrams are buffered and released only after the stop.
// R14: telegrams for other addresses are ignored with sda released.
`timescale 1ns/100ps
module tbp_port (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       link_clk,
  input  wire logic       scl_line,
  output logic            scl_pull,
  output logic            scl_oe,
  input  wire logic       sda_line,
  output logic            sda_pull,
  output logic            sda_oe,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [7:0]      wr_sub,
  output logic [7:0]      wr_byte,
  output logic            wr_last,
  input  wire logic [7:0] rd_byte,
  output logic            rd_strobe,
  input  wire logic       cmd_busy,
  input  wire logic       cmd_invalid,
  input  wire logic       cmd_nodata
);
  // link domain state
  tbp_pkg::tbp_lstate_t lstate;
  logic [4:0]             lsync;
  logic                   scl_q;
  logic                   sda_q;
  logic [3:0]             bitcnt;
  logic [7:0]             shreg;
  logic                   rnw;
  logic                   first;
  logic                   ack_drv;
  logic                   ev_req;
  logic [tbp_pkg::EV_W-1:0] ev_word;
  logic [tbp_pkg::EV_W-1:0] need_word;
  logic                   byte_need;
  logic                   stop_pend;
  logic                   tx_seen;
  logic                   tx_wait;
  logic [7:0]             tx_sh;
  logic                   oe_q;
  logic                   let_go;
  // core domain state
  tbp_pkg::tbp_cstate_t cstate;
  logic                   ev_req_s;
  logic                   ev_seen;
  logic                   busy;
  logic [7:0]             tx_byte;
  logic                   tx_tog;
  logic [7:0]             csub;
  logic [8:0]             len;
  logic [5:0]             fill;
  logic [5:0]             cp;
  logic                   final_copy;
  logic [7:0]             stash [tbp_pkg::BUF_BYTES];
  logic [7:0]             status;
  logic                   f_ir;
  logic                   f_ov;
  logic [tbp_pkg::EV_W-1:0] f_data;

  tbp_sync #(.W(5)) u_lsync (
    .clk    (link_clk),
    .arst_n (arst_n),
    .d      ({scl_line, sda_line, ev_seen, busy, tx_tog}),
    .q      (lsync)
  );

  wire scl_s    = lsync[4];
  wire sda_s    = lsync[3];
  wire ev_ack_s = lsync[2];
  wire busy_s   = lsync[1];
  wire tx_tog_s = lsync[0];

  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire start_c   = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c    = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_done = scl_fall & (bitcnt == tbp_pkg::BYTE_BITS);
  wire addr_hit  = shreg[7:1] == tbp_pkg::SLV_ADDR;
  wire active    = (lstate == tbp_pkg::L_AACK) | (lstate == tbp_pkg::L_WR)
                 | (lstate == tbp_pkg::L_WACK) | (lstate == tbp_pkg::L_RD)
                 | (lstate == tbp_pkg::L_RACK);
  wire ev_pend   = ev_req ^ ev_ack_s;
  wire tx_new    = tx_tog_s ^ tx_seen;
  wire send_stop = ~ev_pend & stop_pend;
  wire send_byte = ~ev_pend & ~stop_pend & byte_need;
  wire wr_done   = byte_done & (lstate == tbp_pkg::L_WR);
  wire addr_rd   = byte_done & (lstate == tbp_pkg::L_ADDR) & addr_hit
                 & shreg[0];
  wire rack_ok   = scl_rise & (lstate == tbp_pkg::L_RACK) & ~sda_s;
  wire rd_ask    = addr_rd | rack_ok;
  // hold covers unsent events too, so at most one byte is ever in flight
  wire hold      = ev_pend | stop_pend | byte_need | busy_s | tx_wait;

  assign scl_pull = 1'b0;
  assign sda_pull = 1'b0;
  assign scl_oe   = active & ~scl_s & hold & ~let_go; // R2 R8 R9
  assign sda_oe   = ack_drv | ((lstate == tbp_pkg::L_RD) & ~tx_wait
                  & ~tx_sh[7]); // R1

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // once let go, scl is not pulled again until it is seen high: scl_s lags
  // the wire, so a late busy would otherwise cut the high phase short
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_q   <= 1'b0;
      let_go <= 1'b0;
    end else begin
      oe_q <= scl_oe;
      if (scl_rise) let_go <= 1'b0;
      else if (oe_q && !scl_oe) let_go <= 1'b1; // R2
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lstate  <= tbp_pkg::L_IDLE;
      bitcnt  <= '0;
      shreg   <= '0;
      rnw     <= 1'b0;
      first   <= 1'b0;
      ack_drv <= 1'b0;
    end else if (start_c) begin
      lstate  <= tbp_pkg::L_ADDR;
      bitcnt  <= '0;
      ack_drv <= 1'b0;
    end else if (stop_c) begin
      lstate  <= tbp_pkg::L_IDLE;
      ack_drv <= 1'b0;
    end else begin
      unique case (lstate)
        tbp_pkg::L_IDLE, tbp_pkg::L_IGN: begin
        end
        tbp_pkg::L_ADDR, tbp_pkg::L_WR: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 1'b1;
          end else if (byte_done) begin
            bitcnt <= '0;
            if (lstate == tbp_pkg::L_WR) begin
              ack_drv <= 1'b1; // R6
              first   <= 1'b0;
              lstate  <= tbp_pkg::L_WACK;
            end else if (addr_hit) begin
              ack_drv <= 1'b1; // R10
              rnw     <= shreg[0];
              first   <= ~shreg[0];
              lstate  <= tbp_pkg::L_AACK;
            end else begin
              lstate  <= tbp_pkg::L_IGN; // R3 R14
            end
          end
        end
        tbp_pkg::L_AACK, tbp_pkg::L_WACK: begin
          if (scl_fall) begin
            ack_drv <= 1'b0;
            lstate  <= (lstate == tbp_pkg::L_AACK && rnw) ? tbp_pkg::L_RD
                                                         : tbp_pkg::L_WR;
          end
        end
        tbp_pkg::L_RD: begin
          if (scl_fall) begin
            bitcnt <= bitcnt + 1'b1;
            if (bitcnt == tbp_pkg::LAST_BIT) lstate <= tbp_pkg::L_RACK;
          end
        end
        tbp_pkg::L_RACK: begin
          if (scl_rise && sda_s) begin
            lstate <= tbp_pkg::L_IGN;
          end else if (scl_fall) begin
            bitcnt <= '0;
            lstate <= tbp_pkg::L_RD;
          end
        end
      endcase
    end
  end

  // one event channel to the core; a stop always goes out first
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_need <= 1'b0;
      need_word <= '0;
      stop_pend <= 1'b0;
      ev_req    <= 1'b0;
      ev_word   <= '0;
    end else begin
      if (send_byte) byte_need <= 1'b0;
      if (wr_done) begin
        byte_need <= 1'b1;
        need_word <= {first ? tbp_pkg::EV_SUB : tbp_pkg::EV_DATA, shreg}; // R4
      end else if (rd_ask) begin
        byte_need <= 1'b1;
        need_word <= {tbp_pkg::EV_RD, shreg};
      end
      if (send_stop) stop_pend <= 1'b0;
      if (stop_c && active) stop_pend <= 1'b1; // R13
      if (send_stop || send_byte) begin
        ev_req  <= ~ev_req;
        ev_word <= send_stop ? {tbp_pkg::EV_STOP, tbp_pkg::STOP_PAD}
                             : need_word;
      end
    end
  end

  // tx_byte is stable once its toggle is seen through the synchroniser
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_seen <= 1'b0;
      tx_wait <= 1'b0;
      tx_sh   <= '0;
    end else begin
      if (tx_new) begin
        tx_seen <= tx_tog_s;
        tx_wait <= 1'b0;
        tx_sh   <= tx_byte;
      end else if (scl_fall && lstate == tbp_pkg::L_RD) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
      if (rd_ask) tx_wait <= 1'b1;
    end
  end

  // core side
  tbp_sync #(.W(1)) u_csync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (ev_req),
    .q      (ev_req_s)
  );

  wire ev_in = ev_req_s ^ ev_seen;

  wire                  out_free  = ~wr_valid | wr_ready;
  wire                  pop_ok    = (cstate != tbp_pkg::C_COPY) & out_free;
  wire                  pop       = f_ov & pop_ok;
  tbp_pkg::tbp_ev_t     kind;
  wire [7:0]            dat       = f_data[7:0];
  wire                  len_ok    = len != tbp_pkg::MAX_LEN;
  wire                  take      = pop & (kind == tbp_pkg::EV_DATA) & len_ok;
  wire                  coll_sub  = (dat == tbp_pkg::SUB_DRAM)
                                  | (dat == tbp_pkg::SUB_CMD);
  wire                  buf_wr    = take & (cstate == tbp_pkg::C_COLLECT)
                                  & (fill != tbp_pkg::BUF_FULL);
  wire                  full_now  = buf_wr & (fill == tbp_pkg::BUF_LAST)
                                  & (csub == tbp_pkg::SUB_DRAM);
  wire                  stop_pop  = pop & (kind == tbp_pkg::EV_STOP);
  wire                  stop_now  = stop_pop & (cstate == tbp_pkg::C_COLLECT)
                                  & (fill != '0);
  wire                  copy_step = (cstate == tbp_pkg::C_COPY) & out_free
                                  & (cp != fill);
  wire                  copy_done = (cstate == tbp_pkg::C_COPY)
                                  & (cp == fill);
  wire                  direct_wr = take & (cstate == tbp_pkg::C_DIRECT);
  wire                  rd_now    = pop & (kind == tbp_pkg::EV_RD);
  wire                  is_stat   = csub == tbp_pkg::SUB_STAT;

  assign kind = tbp_pkg::tbp_ev_t'(f_data[9:8]);

  tbp_fifo #(.W(tbp_pkg::EV_W), .D(tbp_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (ev_in),
    .in_ready  (f_ir),
    .in_data   (ev_word),
    .out_valid (f_ov),
    .out_ready (pop_ok),
    .out_data  (f_data)
  );

  always_comb begin
    status = '0;
    status[tbp_pkg::ST_BUSY]    = cmd_busy; // R11
    status[tbp_pkg::ST_INVALID] = cmd_invalid;
    status[tbp_pkg::ST_NODATA]  = cmd_nodata;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_seen <= 1'b0;
      busy    <= 1'b0;
    end else begin
      if (ev_in && f_ir) ev_seen <= ev_req_s; // R7
      busy <= (cstate == tbp_pkg::C_COPY) | f_ov; // R8 R9
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cstate     <= tbp_pkg::C_SUB;
      csub       <= '0;
      final_copy <= 1'b0;
    end else if (pop && kind == tbp_pkg::EV_SUB) begin
      csub   <= dat; // R4
      cstate <= coll_sub ? tbp_pkg::C_COLLECT : tbp_pkg::C_DIRECT;
    end else if (full_now || stop_now) begin
      cstate     <= tbp_pkg::C_COPY; // R12 R13
      final_copy <= stop_now;
    end else if (copy_done) begin
      cstate <= final_copy ? tbp_pkg::C_SUB : tbp_pkg::C_COLLECT;
    end else if (stop_pop) begin
      cstate <= tbp_pkg::C_SUB;
    end
  end

  // bytes past the telegram limit are dropped rather than wrapped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      len  <= '0;
      fill <= '0;
      cp   <= '0;
    end else begin
      if (pop && kind == tbp_pkg::EV_SUB) len <= '0;
      else if (take) len <= len + 1'b1; // R5
      if ((pop && kind == tbp_pkg::EV_SUB) || copy_done) fill <= '0;
      else if (buf_wr) fill <= fill + 1'b1;
      if (full_now || stop_now) cp <= '0;
      else if (copy_step) cp <= cp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (buf_wr) stash[fill] <= dat; // R7
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid <= 1'b0;
      wr_sub   <= '0;
      wr_byte  <= '0;
      wr_last  <= 1'b0;
    end else if (direct_wr || copy_step) begin
      wr_valid <= 1'b1; // R6
      wr_sub   <= csub;
      wr_byte  <= direct_wr ? dat : stash[cp];
      wr_last  <= copy_step & final_copy & (cp == fill - 1'b1);
    end else if (wr_ready) begin
      wr_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_byte   <= '0;
      tx_tog    <= 1'b0;
      rd_strobe <= 1'b0;
    end else begin
      rd_strobe <= rd_now & ~is_stat;
      if (rd_now) begin
        tx_byte <= is_stat ? status : rd_byte; // R11
        tx_tog  <= ~tx_tog;
      end
    end
  end

  property p_ack_addr;
    @(posedge link_clk) disable iff (!arst_n)
    (byte_done && !start_c && !stop_c && lstate == tbp_pkg::L_ADDR
     && addr_hit) |=> (sda_oe && lstate == tbp_pkg::L_AACK);
  endproperty
  a_ack_addr: assert property (p_ack_addr) // R10
    else $error("own address not acknowledged");

  property p_gc_nack;
    @(posedge link_clk) disable iff (!arst_n)
    (byte_done && !start_c && !stop_c && lstate == tbp_pkg::L_ADDR
     && shreg[7:1] == tbp_pkg::GEN_CALL) |=> (!sda_oe && lstate == tbp_pkg::L_IGN);
  endproperty
  a_gc_nack: assert property (p_gc_nack) // R3
    else $error("general call was acknowledged");

  property p_ignore;
    @(posedge link_clk) disable iff (!arst_n)
    (lstate == tbp_pkg::L_IGN) |-> (!sda_oe && !scl_oe);
  endproperty
  a_ignore: assert property (p_ignore) // R14
    else $error("foreign telegram disturbed the bus");

  property p_sub_first;
    @(posedge link_clk) disable iff (!arst_n)
    (wr_done && first && !start_c && !stop_c) |=>
      (byte_need && need_word[9:8] == tbp_pkg::EV_SUB);
  endproperty
  a_sub_first: assert property (p_sub_first) // R4
    else $error("first write byte not tagged as subaddress");

  property p_hold_low;
    @(posedge link_clk) disable iff (!arst_n)
    (lstate == tbp_pkg::L_AACK && !scl_s && busy_s && !let_go)
      |-> scl_oe [*1];
  endproperty
  a_hold_low: assert property (p_hold_low) // R9
    else $error("clock not held after address while busy");

  property p_stop_kept;
    @(posedge link_clk) disable iff (!arst_n)
    (stop_c && active) |=> stop_pend;
  endproperty
  a_stop_kept: assert property (p_stop_kept) // R13
    else $error("stop not forwarded");

  property p_ack_release;
    @(posedge link_clk) disable iff (!arst_n)
    (lstate == tbp_pkg::L_WACK && scl_fall && !start_c && !stop_c)
      |=> (!sda_oe && lstate == tbp_pkg::L_WR);
  endproperty
  a_ack_release: assert property (p_ack_release) // R1
    else $error("data line not released after acknowledge");

  property p_dram_full;
    @(posedge clk) disable iff (!arst_n)
    full_now |=> (cstate == tbp_pkg::C_COPY && fill == tbp_pkg::BUF_FULL
                  && !final_copy);
  endproperty
  a_dram_full: assert property (p_dram_full) // R12
    else $error("full dram buffer not copied");

  property p_copy_busy;
    @(posedge clk) disable iff (!arst_n)
    (cstate == tbp_pkg::C_COPY) |=> busy;
  endproperty
  a_copy_busy: assert property (p_copy_busy) // R8
    else $error("busy missing during copy");

  property p_status;
    @(posedge clk) disable iff (!arst_n)
    (rd_now && is_stat) |=>
      (tx_byte[1:0] == 2'h0 && tx_byte[7] == $past(cmd_busy)
       && tx_byte[6] == $past(cmd_invalid) && !rd_strobe);
  endproperty
  a_status: assert property (p_status) // R11
    else $error("status byte wrong");

  c_write: cover property (@(posedge link_clk) disable iff (!arst_n)
    lstate == tbp_pkg::L_WACK && scl_fall);
  c_read: cover property (@(posedge link_clk) disable iff (!arst_n)
    rack_ok);
  c_stretch: cover property (@(posedge link_clk) disable iff (!arst_n)
    scl_oe && busy_s);
  c_final_copy: cover property (@(posedge clk) disable iff (!arst_n)
    copy_done && final_copy);
endmodule

// File: verif/tbp_host.sv
// Purpose: host master model on the two-wire bus
// Assumes: bench resolves the open-drain wires with pull-ups
// Notes:   bus bit time is far slower than link oversampling
`timescale 1ns/100ps
module tbp_host #(
  parameter int Q = 200
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_dn,
  output logic      sda_dn
);
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end

  task automatic scl_rise();
    int n;
    scl_dn = 1'b0;
    // a stretching slave may hold the wire, so wait for it
    for (n = 0; n < 100000 && scl !== 1'b1; n++) #5;
  endtask

  task automatic clk_bit(input logic b, output logic s);
    sda_dn = !b;
    #Q scl_rise();
    #Q s = sda;
    #Q scl_dn = 1'b1;
    #Q;
  endtask

  task automatic start();
    sda_dn = 1'b0;
    #Q scl_rise();
    #Q sda_dn = 1'b1;
    #Q scl_dn = 1'b1;
    #Q;
  endtask

  task automatic stop();
    sda_dn = 1'b1;
    #Q scl_rise();
    #Q sda_dn = 1'b0;
    #Q;
  endtask

  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    int   i;
    for (i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic get(input logic more, output logic [7:0] d);
    logic s;
    int   i;
    for (i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(!more, s);
  endtask
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench of the buffered two-wire slave port
// Assumes: host model on the bus, random stalls on the core side
// Notes:   expected core words are queued as telegrams are sent
`timescale 1ns/100ps
module tb;
  logic        clk, arst_n, link_clk, scl, sda, m_scl_dn, m_sda_dn;
  logic        scl_pull, scl_oe, sda_pull, sda_oe;
  logic        wr_valid, wr_ready, wr_last, rd_strobe, ack;
  logic        cmd_busy, cmd_invalid, cmd_nodata;
  logic [7:0]  wr_sub, wr_byte, rd_byte;
  logic [6:0]  other [2] = '{tbp_pkg::GEN_CALL, 7'h30};
  logic [16:0] exp_q [$];
  int          bad_count, samples_checked, strobes, stretch;
  int unsigned seed_v;

  assign scl = !(scl_oe | m_scl_dn);
  assign sda = !(sda_oe | m_sda_dn);

  tbp_port u_dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk),
    .scl_line(scl), .scl_pull(scl_pull), .scl_oe(scl_oe),
    .sda_line(sda), .sda_pull(sda_pull), .sda_oe(sda_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_sub(wr_sub),
    .wr_byte(wr_byte), .wr_last(wr_last), .rd_byte(rd_byte),
    .rd_strobe(rd_strobe), .cmd_busy(cmd_busy),
    .cmd_invalid(cmd_invalid), .cmd_nodata(cmd_nodata));
  tbp_host u_host (.scl(scl), .sda(sda), .scl_dn(m_scl_dn),
    .sda_dn(m_sda_dn));

  always #12.5 clk = !clk;
  always #32 link_clk = !link_clk;
  // stalls on the core side push the fifo back onto the bus
  always @(negedge clk) wr_ready <= ($urandom_range(3) != 0);

  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (exp_q.size() == 0)
        check("wr_extra", 1, 0);
      else
        check("wr_word", {wr_sub, wr_byte, wr_last}, exp_q.pop_front());
    end
    if (rd_strobe === 1'b1) strobes++;
    if (scl_oe === 1'b1) stretch++;
  end

  function automatic logic [1:0] plan_byte(logic [7:0] s, int i, int n);
    int k;
    k = (n < tbp_pkg::BUF_BYTES) ? n : tbp_pkg::BUF_BYTES;
    if (s == tbp_pkg::SUB_CMD)
      return {i < k, i == k - 1};
    if (s == tbp_pkg::SUB_DRAM)
      return {1'b1, i == n - 1};
    return 2'b10;
  endfunction

  function automatic logic [7:0] stat_exp();
    logic [7:0] s;
    s = 8'h00;
    s[tbp_pkg::ST_BUSY] = cmd_busy;
    s[tbp_pkg::ST_INVALID] = cmd_invalid;
    s[tbp_pkg::ST_NODATA] = cmd_nodata;
    return s;
  endfunction

  task automatic drain();
    int i;
    for (i = 0; i < 20000 && exp_q.size() != 0; i++) @(posedge clk);
    check("drained", exp_q.size(), 0);
  endtask

  task automatic wr_tel(input logic [7:0] sub, input int n);
    logic [7:0] d;
    logic [1:0] p;
    int         i;
    u_host.start();
    u_host.put({tbp_pkg::SLV_ADDR, 1'b0}, ack);
    check("addr_ack", ack, 1);
    u_host.put(sub, ack);
    check("sub_ack", ack, 1);
    for (i = 0; i < n; i++) begin
      d = $urandom;
      p = plan_byte(sub, i, n);
      if (p[1]) exp_q.push_back({sub, d, p[0]});
      u_host.put(d, ack);
      check("data_ack", ack, 1);
    end
    if (sub == tbp_pkg::SUB_CMD)
      check("cmd_held", exp_q.size(), (n < 48) ? n : 48);
    u_host.stop();
  endtask

  task automatic rd_tel(input logic [7:0] sub, input int n,
                        input logic [7:0] want);
    logic [7:0] d;
    int         i;
    if (sub != 8'h00) begin
      u_host.start();
      u_host.put({tbp_pkg::SLV_ADDR, 1'b0}, ack);
      u_host.put(sub, ack);
    end
    u_host.start();
    u_host.put({tbp_pkg::SLV_ADDR, 1'b1}, ack);
    check("rd_ack", ack, 1);
    for (i = 0; i < n; i++) begin
      u_host.get(i < n - 1, d);
      check("rd_data", d, want);
    end
    u_host.stop();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #2400000;
    bad_count++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    arst_n = 1'b0;
    rd_byte = 8'h00;
    {cmd_busy, cmd_invalid, cmd_nodata} = 3'h0;
    seed_v = $urandom(32'h99990746);
    repeat (12) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    repeat (40) @(negedge clk);
    rd_byte = $urandom;
    {cmd_busy, cmd_invalid, cmd_nodata} = $urandom;
    wr_tel(tbp_pkg::SUB_CPU_FIX, 3);
    wr_tel(tbp_pkg::SUB_CPU_INC, 1 + $urandom_range(20));
    wr_tel(tbp_pkg::SUB_DATA, 2);
    drain();
    stretch = 0;
    wr_tel(tbp_pkg::SUB_DRAM, 50);
    check("held_scl", stretch != 0, 1);
    drain();
    wr_tel(tbp_pkg::SUB_CMD, 5);
    drain();
    wr_tel(tbp_pkg::SUB_CMD, 50);
    wr_tel(tbp_pkg::SUB_CPU_FIX, 2);
    drain();
    rd_tel(tbp_pkg::SUB_STAT, 1, stat_exp());
    @(negedge clk) {cmd_busy, cmd_invalid, cmd_nodata} = ~{cmd_busy,
      cmd_invalid, cmd_nodata};
    foreach (other[k]) begin
      u_host.start();
      u_host.put({other[k], 1'b0}, ack);
      check("foreign_ack", ack, 0);
      u_host.put(tbp_pkg::SUB_DATA, ack);
      u_host.stop();
    end
    rd_tel(8'h00, 1, stat_exp());
    strobes = 0;
    rd_tel(tbp_pkg::SUB_DATA, 2, rd_byte);
    check("rd_pulses", strobes, 2);
    check("pulls", {scl_pull, sda_pull}, 2'b00);
    drain();
    complete_run();
  end
endmodule
